// *** hw/ssfp_pkg.sv ***
// Package of constants and types for the flow-through burst SRAM port.
// How it works
// - Address captured on qualified rising clock edge.
// - Low two address bits seed burst counter.
// - Active-low byte lanes write only with strobe.
// - Write strobe sampled only while clock gate low.
// - Step high with gate low advances counter.
// - Step low loads a fresh address.
// - Only gated edges act; inputs captured then.
// - Gate high holds control state; queued writes still drain.
// - Gate high never deselects the device.
// - Select needs cs_a low, cs_high high, cs_b low.
// - Output-drive low drives pins, high floats them.
// - Pins float on writes, first-select, deselect.
// - Sleep input idles device, keeps contents.
// - Sleep low or open means normal operation.
// - Read returns location captured previous edge.
// - Strap low linear, high interleaved burst order.
package ssfp_pkg;
   localparam int          SSFP_ADDR_W   = 10;    // Word address width.
   localparam int          SSFP_LANES    = 4;     // Byte lanes per word.
   localparam int          SSFP_LANE_W   = 9;     // Bits per lane, parity.
   localparam int          SSFP_DATA_W   = SSFP_LANES * SSFP_LANE_W;
   localparam int          SSFP_BUF_DEPTH = 2;    // Write buffer entries.
   localparam logic [1:0]  SSFP_SEED_RST = 2'h0;  // Counter reset value.
   localparam logic [1:0]  SSFP_STEP_ONE = 2'h1;  // Linear step increment.
   // Operation captured on a qualified edge.
   typedef enum logic [1:0] {
      SSFP_OP_IDLE,
      SSFP_OP_READ,
      SSFP_OP_WRITE
   } ssfp_op_t;
endpackage

// *** hw/ssfp_burst_ctr.sv ***
// Two-bit burst counter with linear or interleaved order.
`timescale 1ns/10ps
module ssfp_burst_ctr (
   input  wire logic       mclk,        // Clock.
   input  wire logic       arst_n,      // Asynchronous reset, active low.
   input  wire logic       load,        // Seed from the low address bits.
   input  wire logic       step,        // Advance one position.
   input  wire logic [1:0] seed,        // Low address bits.
   input  wire logic       interleave,  // High selects interleaved order.
   output logic      [1:0] low_addr     // Current low address bits.
);
   import ssfp_pkg::*;
   logic [1:0] seed_reg;   // Seed of the current burst.
   logic [1:0] seed_next;  // Next seed.
   logic [1:0] cnt_reg;    // Position within the burst.
   logic [1:0] cnt_next;   // Next position.

   // Next state: load restarts, step advances, otherwise hold.
   always_comb begin
      seed_next = seed_reg;
      cnt_next  = cnt_reg;
      if (load) begin
         seed_next = seed;
         cnt_next  = SSFP_SEED_RST;
      end else if (step) begin
         cnt_next  = cnt_reg + SSFP_STEP_ONE;
      end
   end

   // State registers.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         seed_reg <= SSFP_SEED_RST;
         cnt_reg  <= SSFP_SEED_RST;
      end else begin
         seed_reg <= seed_next;
         cnt_reg  <= cnt_next;
      end
   end

   // Two bits wrap in a group of four either way.
   assign low_addr = interleave ? (seed_reg ^ cnt_reg)
                                : (seed_reg + cnt_reg);
endmodule

// *** hw/ssfp_wbuf.sv ***
// Two-entry valid/ready buffer for write words.
`timescale 1ns/10ps
module ssfp_wbuf #(
   parameter int W     = 50,  // Entry width.
   parameter int DEPTH = 2    // Entry count, power of two.
) (
   input  wire logic         mclk,     // Clock.
   input  wire logic         arst_n,   // Asynchronous reset, active low.
   input  wire logic         in_valid, // Word offered.
   output logic              in_ready, // Room available.
   input  wire logic [W-1:0] in_data,  // Word in.
   output logic              out_valid,// Word present.
   input  wire logic         out_ready,// Drain takes word.
   output logic      [W-1:0] out_data  // Oldest word.
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];        // Storage.
   logic [PW:0]  wp_reg, wp_next;    // Write pointer.
   logic [PW:0]  rp_reg, rp_next;    // Read pointer.
   logic         push, pop;          // Handshake events.

   assign in_ready  = (wp_reg - rp_reg) != (PW+1)'(DEPTH);
   assign out_valid = wp_reg != rp_reg;
   assign out_data  = mem[rp_reg[PW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer updates.
   always_comb begin
      wp_next = push ? wp_reg + 1'b1 : wp_reg;
      rp_next = pop  ? rp_reg + 1'b1 : rp_reg;
   end

   // Pointer registers.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         wp_reg <= wp_next;
         rp_reg <= rp_next;
      end
   end

   // Storage is written without reset; it holds data only.
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wp_reg[PW-1:0]] <= in_data;
      end
   end
endmodule

// *** hw/ssfp_top.sv ***
// Flow-through burst SRAM port: control, array and data pins.
`timescale 1ns/10ps
module ssfp_top #(
   parameter int ADDR_W = ssfp_pkg::SSFP_ADDR_W,  // Word address width.
   parameter int LANES  = ssfp_pkg::SSFP_LANES,   // Byte lanes.
   parameter int LANE_W = ssfp_pkg::SSFP_LANE_W   // Bits per lane.
) (
   input  wire logic                    mclk,              // Clock.
   input  wire logic                    arst_n,            // Reset, low.
   input  wire logic [ADDR_W-1:0]       addr,              // Address.
   input  wire logic                    write_n,           // Write strobe.
   input  wire logic [LANES-1:0]        byte_lane_write_n, // Lane selects.
   input  wire logic                    chip_select_low_a, // Select, low.
   input  wire logic                    chip_select_high,  // Select, high.
   input  wire logic                    chip_select_low_b, // Select, low.
   input  wire logic                    load_or_step,      // High steps.
   input  wire logic                    clock_gate_n,      // Edge qualify.
   input  wire logic                    out_drive_n,       // Async drive.
   input  wire logic                    sleep_request,     // Async sleep.
   input  wire logic                    burst_mode,        // High interlv.
   input  wire logic [LANES*LANE_W-1:0] dq_in,             // Pin level.
   output logic      [LANES*LANE_W-1:0] dq_out,            // Read data.
   output logic                         dq_oe,             // Pin drive.
   output logic                         sleeping           // In sleep.
);
   import ssfp_pkg::*;
   localparam int DW    = LANES * LANE_W;
   localparam int WORDS = 1 << ADDR_W;
   localparam int BW    = ADDR_W + LANES;

   logic [DW-1:0]     mem [WORDS];       // Storage array.
   logic              qual;              // Qualified edge.
   logic              sel_now;           // Select decode.
   logic              sel_reg, sel_next; // Selected in last cycle.
   logic              fresh_reg, fresh_next; // First selected cycle.
   ssfp_op_t          op_reg, op_next;   // Operation captured.
   logic [ADDR_W-1:0] base_reg, base_next; // Captured address.
   logic [LANES-1:0]  lane_reg, lane_next; // Captured lane selects.
   logic [1:0]        low_addr;          // Burst low bits.
   logic [ADDR_W-1:0] cur_addr;          // Effective word address.
   logic [DW-1:0]     rdata_reg, rdata_next; // Read data register.
   logic              mode_reg, mode_next;   // Strap latched.
   logic              mode_cap_reg;      // Strap captured once.
   logic              wb_in_valid, wb_in_ready, wb_out_valid;
   logic [BW-1:0]     wb_in_data, wb_out_data;
   logic              ctr_load, ctr_step;

   // Decode of the three chip selects.
   function automatic logic chip_sel(input logic a_n, input logic h,
                                     input logic b_n);
      chip_sel = !a_n && h && !b_n;
   endfunction

   // Gated edges act only when awake; stalls also hold the pipeline.
   assign qual    = !clock_gate_n && !sleep_request && wb_in_ready;
   assign sel_now = chip_sel(chip_select_low_a, chip_select_high,
                             chip_select_low_b);
   assign ctr_load = qual && sel_now && !load_or_step;
   assign ctr_step = qual && sel_reg && load_or_step;

   ssfp_burst_ctr u_ctr (
      .mclk       (mclk),
      .arst_n     (arst_n),
      .load       (ctr_load),
      .step       (ctr_step),
      .seed       (addr[1:0]),
      .interleave (mode_reg),
      .low_addr   (low_addr)
   );

   assign cur_addr = {base_reg[ADDR_W-1:2], low_addr};

   // Control next state; an unqualified edge holds everything.
   always_comb begin
      sel_next   = sel_reg;
      fresh_next = fresh_reg;
      op_next    = op_reg;
      base_next  = base_reg;
      lane_next  = lane_reg;
      if (qual) begin
         fresh_next = sel_now && !sel_reg;
         if (!load_or_step && sel_now) begin
            sel_next  = 1'b1;
            base_next = addr;
            op_next   = write_n ? SSFP_OP_READ : SSFP_OP_WRITE;
            lane_next = byte_lane_write_n;
         end else if (load_or_step && sel_reg) begin
            // Burst continues with the same direction.
            lane_next = byte_lane_write_n;
         end else begin
            // Deselect load, or a step while deselected: stay idle.
            sel_next = 1'b0;
            op_next  = SSFP_OP_IDLE;
         end
      end
   end

   // Control registers.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sel_reg   <= 1'b0;
         fresh_reg <= 1'b0;
         op_reg    <= SSFP_OP_IDLE;
         base_reg  <= '0;
         lane_reg  <= '1;
      end else begin
         sel_reg   <= sel_next;
         fresh_reg <= fresh_next;
         op_reg    <= op_next;
         base_reg  <= base_next;
         lane_reg  <= lane_next;
      end
   end

   // Strap caught once after reset release.
   always_comb begin
      mode_next = mode_cap_reg ? mode_reg : burst_mode;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mode_reg     <= 1'b1;
         mode_cap_reg <= 1'b0;
      end else begin
         mode_reg     <= mode_next;
         mode_cap_reg <= 1'b1;
      end
   end

   // Write data arrives the edge after the command and queues.
   assign wb_in_valid = !clock_gate_n && !sleep_request &&
                        op_reg == SSFP_OP_WRITE;
   assign wb_in_data  = {cur_addr, lane_reg};

   ssfp_wbuf #(
      .W     (BW),
      .DEPTH (SSFP_BUF_DEPTH)
   ) u_wbuf (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .in_valid  (wb_in_valid),
      .in_ready  (wb_in_ready),
      .in_data   (wb_in_data),
      .out_valid (wb_out_valid),
      .out_ready (1'b1),
      .out_data  (wb_out_data)
   );

   // Data word captured alongside the buffered entry.
   logic [DW-1:0] wdata_reg;  // Write data held for array.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wdata_reg <= '0;
      end else if (wb_in_valid && wb_in_ready) begin
         wdata_reg <= dq_in;
      end
   end

   // Per-lane write enables; active-low selects gate each byte.
   logic [LANES-1:0] lane_we;  // Lane written this edge.
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         assign lane_we[g] = wb_out_valid && !wb_out_data[g];
      end
   endgenerate

   // One process owns the array so it has a single driver.
   always_ff @(posedge mclk) begin
      for (int i = 0; i < LANES; i++) begin
         if (lane_we[i]) begin
            mem[wb_out_data[BW-1:LANES]][i*LANE_W +: LANE_W]
               <= wdata_reg[i*LANE_W +: LANE_W];
         end
      end
   end

   // Read data from the address captured at the previous edge.
   always_comb begin
      rdata_next = rdata_reg;
      if (op_reg == SSFP_OP_READ && !sleep_request) begin
         rdata_next = mem[cur_addr];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // Flow-through: combinational view of the selected word.
   assign dq_out = (op_reg == SSFP_OP_READ) ? mem[cur_addr] : rdata_reg;

   // Drive only on reads, masked by write, first-select and deselect.
   assign dq_oe = !out_drive_n && sel_reg && !fresh_reg &&
                  op_reg == SSFP_OP_READ && !sleep_request;

   // Sleep freezes control state; a write queued before it still drains into the array.
   assign sleeping = sleep_request;

   chk_gate_hold: assert property (@(posedge mclk) disable iff (!arst_n)
      clock_gate_n |=> $stable(sel_reg) && $stable(base_reg))
      else $error("State changed while clock gated.");
   chk_load_addr: assert property (@(posedge mclk) disable iff (!arst_n)
      ctr_load |=> base_reg == $past(addr) && low_addr == $past(addr[1:0]))
      else $error("Address not captured on load.");
   chk_sel_decode: assert property (@(posedge mclk) disable iff (!arst_n)
      qual && !load_or_step && !sel_now |=> !sel_reg)
      else $error("Selected without valid chip selects.");
   chk_oe_mask: assert property (@(posedge mclk) disable iff (!arst_n)
      (op_reg == SSFP_OP_WRITE || !sel_reg || fresh_reg) |-> !dq_oe)
      else $error("Pins driven when masked.");
   chk_oe_async: assert property (@(posedge mclk) disable iff (!arst_n)
      out_drive_n |-> !dq_oe)
      else $error("Pins driven with drive input high.");
   chk_write_op: assert property (@(posedge mclk) disable iff (!arst_n)
      ctr_load && !write_n |=> op_reg == SSFP_OP_WRITE)
      else $error("Write strobe not captured.");
   chk_step_ctr: assert property (@(posedge mclk) disable iff (!arst_n)
      ctr_step && !mode_reg |=> low_addr == $past(low_addr) + 2'h1)
      else $error("Linear step wrong.");
   chk_sleep_hold: assert property (@(posedge mclk) disable iff (!arst_n)
      sleep_request |=> $stable(op_reg))
      else $error("State moved during sleep.");
endmodule

// *** bench/ssfp_master.sv ***
// Bus master model that drives the port's pins after each falling edge.
`timescale 1ns/10ps
module ssfp_master import ssfp_pkg::*; (
   input  wire logic                   mclk,    // Clock.
   input  wire logic [SSFP_DATA_W-1:0] dq_out,  // Device read data.
   input  wire logic                   dq_oe,   // Device drives the pins.
   output logic      [SSFP_ADDR_W-1:0] addr,    // Address.
   output logic                        write_n, // Write strobe.
   output logic      [SSFP_LANES-1:0]  lanes_n, // Lane selects.
   output logic      [2:0]             cs,      // Selects low_a, high, low_b.
   output logic                        step,    // Low loads, high steps.
   output logic                        gate_n,  // Clock gate.
   output logic                        drive_n, // Output drive.
   output logic                        sleep,   // Sleep request.
   output logic                        mode,    // Burst order strap.
   output logic      [SSFP_DATA_W-1:0] dq_in    // Resolved pin level.
);
   logic [SSFP_DATA_W-1:0] drv;      // Master's own drive of the pins.
   logic [SSFP_DATA_W-1:0] pend;     // Write word due at the next edge.
   logic                   has_pend; // A write command awaits its data.
   // The pins carry the device's word whenever the device drives them.
   assign dq_in = dq_oe ? dq_out : drv;
   // Quiet, deselected start with sleep held low.
   initial begin
      addr = '0;
      write_n = 1'b1;
      lanes_n = '1;
      cs = 3'h5;
      step = 1'b0;
      gate_n = 1'b0;
      drive_n = 1'b0;
      sleep = 1'b0;
      mode = 1'b1;
      drv = '0;
      pend = '0;
      has_pend = 1'b0;
   end
   // One command: pins change after the falling edge, return past the rise.
   task automatic issue(input logic wr, input logic stp,
      input logic [1:0] sel, input logic [SSFP_ADDR_W-1:0] a,
      input logic [SSFP_LANES-1:0] ln, input logic gt, input logic slp,
      input logic [SSFP_DATA_W-1:0] wd);
      @(negedge mclk);
      write_n = ~wr;
      step = stp;
      addr = a;
      lanes_n = ln;
      gate_n = gt;
      sleep = slp;
      cs = (sel == 2'h0) ? 3'h2 : (sel == 2'h1) ? 3'h6 :
           (sel == 2'h2) ? 3'h0 : 3'h3;
      // Write data trails its command by one edge; else the line toggles.
      drv = has_pend ? pend : ~drv;
      if (!gt && !slp) begin
         has_pend = wr;
         pend = wd;
      end
      @(posedge mclk);
      #1;
   endtask
endmodule

// *** bench/test_ssfp_top.sv ***
// Self-checking bench for the flow-through burst SRAM port.
`timescale 1ns/10ps
module test_ssfp_top;
   import ssfp_pkg::*;
   typedef struct packed {
      logic       wr;  // Write command.
      logic       stp; // Step instead of load.
      logic [1:0] sel; // 0 selected, 1..3 one select wrong.
      logic [9:0] a;   // Address.
      logic [3:0] ln;  // Lane selects, active low.
      logic       oe;  // Expected pin drive after the edge.
   } ssfp_row_t;
   localparam ssfp_row_t ROWS [17] = '{
      '{1'b1, 1'b0, 2'h0, 10'h011, 4'h0, 1'b0},
      '{1'b1, 1'b1, 2'h0, 10'h000, 4'h0, 1'b0},
      '{1'b1, 1'b1, 2'h0, 10'h000, 4'h0, 1'b0},
      '{1'b1, 1'b1, 2'h0, 10'h000, 4'h0, 1'b0},
      '{1'b0, 1'b0, 2'h0, 10'h011, 4'hF, 1'b1},
      '{1'b0, 1'b1, 2'h0, 10'h000, 4'hF, 1'b1},
      '{1'b0, 1'b1, 2'h0, 10'h000, 4'hF, 1'b1},
      '{1'b0, 1'b1, 2'h0, 10'h000, 4'hF, 1'b1},
      '{1'b1, 1'b0, 2'h0, 10'h011, 4'hA, 1'b0},
      '{1'b0, 1'b0, 2'h0, 10'h012, 4'hF, 1'b1},
      '{1'b0, 1'b0, 2'h0, 10'h013, 4'h0, 1'b1},
      '{1'b0, 1'b0, 2'h0, 10'h011, 4'hF, 1'b1},
      '{1'b0, 1'b0, 2'h1, 10'h011, 4'hF, 1'b0},
      '{1'b0, 1'b0, 2'h2, 10'h011, 4'hF, 1'b0},
      '{1'b0, 1'b0, 2'h3, 10'h011, 4'hF, 1'b0},
      '{1'b0, 1'b0, 2'h0, 10'h012, 4'hF, 1'b0},
      '{1'b0, 1'b1, 2'h0, 10'h000, 4'hF, 1'b1}};
   logic                   mclk = 1'b0;   // Clock, 4 ns period.
   logic                   arst_n = 1'b0; // Reset, active low.
   logic [SSFP_ADDR_W-1:0] addr;          // Master pin wires.
   logic                   write_n;
   logic [SSFP_LANES-1:0]  lanes_n;
   logic [2:0]             cs;
   logic                   step;
   logic                   gate_n;
   logic                   drive_n;
   logic                   sleep;
   logic                   mode;
   logic [SSFP_DATA_W-1:0] dq_in;         // Resolved pin level.
   logic [SSFP_DATA_W-1:0] dq_out;        // Device outputs.
   logic                   dq_oe;
   logic                   sleeping;
   logic [SSFP_DATA_W-1:0] mem [0:1023];  // Expected array contents.
   int                     failures = 0;  // Mismatch count.
   int                     n_compared = 0;// Comparison count.
   ssfp_top u_ssfp_top (
      .mclk              (mclk),
      .arst_n            (arst_n),
      .addr              (addr),
      .write_n           (write_n),
      .byte_lane_write_n (lanes_n),
      .chip_select_low_a (cs[2]),
      .chip_select_high  (cs[1]),
      .chip_select_low_b (cs[0]),
      .load_or_step      (step),
      .clock_gate_n      (gate_n),
      .out_drive_n       (drive_n),
      .sleep_request     (sleep),
      .burst_mode        (mode),
      .dq_in             (dq_in),
      .dq_out            (dq_out),
      .dq_oe             (dq_oe),
      .sleeping          (sleeping)
   );
   ssfp_master u_ssfp_master (
      .mclk    (mclk),
      .dq_out  (dq_out),
      .dq_oe   (dq_oe),
      .addr    (addr),
      .write_n (write_n),
      .lanes_n (lanes_n),
      .cs      (cs),
      .step    (step),
      .gate_n  (gate_n),
      .drive_n (drive_n),
      .sleep   (sleep),
      .mode    (mode),
      .dq_in   (dq_in)
   );
   // Free-running clock.
   always #2 mclk = ~mclk;
   // Compares one value and reports a mismatch at once.
   task automatic check(input string what, input logic [35:0] seen,
      input logic [35:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic test_done;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Reset with a strap value; the first edge after release is left idle.
   task automatic do_reset(input logic m);
      u_ssfp_master.mode = m;
      arst_n = 1'b0;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check("rst dq_oe", 36'(dq_oe), 36'h0);
      check("rst dq_out", dq_out, 36'h0);
      arst_n = 1'b1;
      // Deselected first; every row table then opens with a load.
      u_ssfp_master.issue(1'b0, 1'b0, 2'h1, '0, 4'hF, 1'b0, 1'b0, '0);
   endtask
   // Runs the row table in one burst order, tracking the burst address.
   task automatic run_rows(input logic m);
      ssfp_row_t        r;
      logic [9:0]       base;
      logic [1:0]       n;
      logic [9:0]       cur;
      logic [35:0]      wd;
      for (int i = 0; i < 17; i++) begin
         r = ROWS[i];
         n = r.stp ? n + 2'h1 : 2'h0;
         base = r.stp ? base : r.a;
         cur = {base[9:2], m ? (base[1:0] ^ n) : (base[1:0] + n)};
         wd = {9'(i * 3 + 1), 9'(i * 5 + 2), 9'(i * 7 + 3), 9'(i + m * 64)};
         for (int g = 0; g < 4; g++) begin
            if (r.wr && !r.ln[g]) begin
               mem[cur][g*9+:9] = wd[g*9+:9];
            end
         end
         u_ssfp_master.issue(r.wr, r.stp, r.sel, r.a, r.ln, 1'b0, 1'b0, wd);
         check("dq_oe", 36'(dq_oe), 36'(r.oe));
         if (r.oe) begin
            check("dq_out", dq_out, mem[cur]);
            check("dq_out", dq_out, mem[cur]);
            check("dq_out", dq_out, mem[cur]);
         end
      end
   endtask
   // Row loops in both orders, then suspension, sleep and drive cases.
   initial begin
      logic [35:0] hold;
      do_reset(1'b0);
      run_rows(1'b0);
      do_reset(1'b1);
      run_rows(1'b1);
      hold = dq_out;
      repeat (3) begin
         u_ssfp_master.issue(1'b1, 1'b0, 2'h1, 10'h3FF, 4'h0, 1'b1, 1'b0, '1);
         check("gate dq_oe", 36'(dq_oe), 36'h1);
         check("gate dq_out", dq_out, hold);
      end
      u_ssfp_master.issue(1'b0, 1'b1, 2'h0, '0, 4'hF, 1'b0, 1'b0, '0);
      check("step dq_out", dq_out, mem[10'h010]);
      u_ssfp_master.issue(1'b1, 1'b0, 2'h0, 10'h010, 4'h0, 1'b0, 1'b1, '0);
      check("sleeping", 36'(sleeping), 36'h1);
      u_ssfp_master.issue(1'b0, 1'b0, 2'h0, 10'h010, 4'hF, 1'b0, 1'b0, '0);
      check("awake", 36'(sleeping), 36'h0);
      check("kept dq_out", dq_out, mem[10'h010]);
      @(negedge mclk);
      u_ssfp_master.drive_n = 1'b1;
      #1;
      check("drive off", 36'(dq_oe), 36'h0);
      u_ssfp_master.drive_n = 1'b0;
      #1;
      check("drive on", 36'(dq_oe), 36'h1);
      test_done();
   end
   // Cuts a hang short well past the expected run length.
   initial begin
      #20000;
      failures++;
      test_done();
   end
endmodule
